// ==== design/btw_pkg.sv ====
package btw_pkg;
    // register map, byte address on the wishbone bus
    localparam logic [7:0] CTRL_OFS       = 8'hD3;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    // status register: counter value, read only
    localparam logic [7:0] COUNT_OFS      = 8'hD4;
    // control field positions
    localparam int         KEY_LSB        = 4;
    localparam int         SEL_LSB        = 2;
    localparam int         CNT_CLR_BIT    = 1;
    localparam int         DIV_CLR_BIT    = 0;
    localparam logic [3:0] WDT_OFF_KEY    = 4'hA;
    // prescaler taps
    localparam int         DIV_WIDTH      = 12;
    localparam logic [11:0] DIV_4096_MAX  = 12'hFFF;
    localparam logic [11:0] DIV_1024_MAX  = 12'h3FF;
    localparam logic [11:0] DIV_128_MAX   = 12'h07F;
    localparam logic [1:0] SEL_4096       = 2'h0;
    localparam logic [1:0] SEL_1024       = 2'h1;
    localparam logic [1:0] SEL_128        = 2'h2;
    localparam logic [7:0] CNT_MAX        = 8'hFF;
    localparam logic [7:0] CNT_RESET      = 8'h00;
endpackage

// ==== design/btw_prescaler.sv ====
`timescale 1ns/1ps
// free-running divider chain with a tap-select tick output
module btw_prescaler
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // control
    input  wire logic        clear,
    input  wire logic [1:0]  sel,
    // tick out
    output logic             tick
);
    logic [btw_pkg::DIV_WIDTH-1:0] div_r; // divider chain
    logic [btw_pkg::DIV_WIDTH-1:0] tap_max; // terminal value of selected tap

    // tap decode; code 11 gives no ticks at all
    always_comb
    begin
        case (sel)
            btw_pkg::SEL_4096: tap_max = btw_pkg::DIV_4096_MAX;
            btw_pkg::SEL_1024: tap_max = btw_pkg::DIV_1024_MAX;
            btw_pkg::SEL_128:  tap_max = btw_pkg::DIV_128_MAX;
            default:           tap_max = '0;
        endcase
    end

    // divider counts every clock, clear wins
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            div_r <= '0;
        else if (clear)
            div_r <= '0;
        else
            div_r <= div_r + 12'h001;
    end

    // tick once each time the low tap bits roll over
    assign tick = (sel != 2'h3) && ((div_r & tap_max) == tap_max);
endmodule

// ==== design/btw_ctrl.sv ====
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// (R01) watchdog off only when key nibble equals 1010
// (R02) prescaler tap 4096, 1024, 128 by code
// (R03) bit0 clears divider, bit1 clears counter
// (R04) clear command bits read back as zero
// (R05) counter ticks; overflow requests reset when enabled
module btw_ctrl
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // system reset request
    output logic             wdt_reset_req
);
    logic [7:0] ctrl_r;       // key and tap select, clear bits held zero
    logic [7:0] cnt_r;        // basic timer counter
    logic       ack_r;        // bus ack
    logic [31:0] dat_r;       // registered read data
    logic       req_r;        // reset request
    logic       wr_ctrl;      // write strobe to control
    logic       div_clr;      // divider clear pulse
    logic       cnt_clr;      // counter clear pulse
    logic       tick;         // prescaler tick
    logic       wdt_en;       // watchdog armed

    // access only when request new; ack lasts one cycle
    assign wr_ctrl = wb_cyc_i && wb_stb_i && !ack_r && wb_we_i
                     && wb_sel_i[0] && (wb_adr_i == btw_pkg::CTRL_OFS);
    // command bits act as pulses, never stored
    assign div_clr = wr_ctrl && wb_dat_i[btw_pkg::DIV_CLR_BIT]; // R03
    assign cnt_clr = wr_ctrl && wb_dat_i[btw_pkg::CNT_CLR_BIT]; // R03
    // any key but the magic one keeps the dog armed
    assign wdt_en = ctrl_r[7:btw_pkg::KEY_LSB] != btw_pkg::WDT_OFF_KEY; // R01

    // prescaler with selectable tap
    btw_prescaler u_pre
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clear   (div_clr),
        .sel     (ctrl_r[btw_pkg::SEL_LSB+1:btw_pkg::SEL_LSB]), // R02
        .tick    (tick)
    );

    // control register; low two bits always zero
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            ctrl_r <= btw_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl_r <= {wb_dat_i[7:2], 2'b00}; // R04
    end

    // bus ack, one cycle, then dropped
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            ack_r <= 1'b0;
        else
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end

    // read data; unmapped addresses read zero
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            dat_r <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !ack_r)
        begin
            case (wb_adr_i)
                btw_pkg::CTRL_OFS:  dat_r <= {24'h000000, ctrl_r}; // R04
                btw_pkg::COUNT_OFS: dat_r <= {24'h000000, cnt_r};
                default:            dat_r <= 32'h0000_0000;
            endcase
        end
    end

    // counter: clear wins over tick
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            cnt_r <= btw_pkg::CNT_RESET;
        else if (cnt_clr)
            cnt_r <= btw_pkg::CNT_RESET; // R03
        else if (tick)
            cnt_r <= cnt_r + 8'h01; // R05
    end

    // overflow request, sticky until system reset takes effect
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            req_r <= 1'b0;
        else if (wdt_en && tick && !cnt_clr && cnt_r == btw_pkg::CNT_MAX)
            req_r <= 1'b1; // R05
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign wdt_reset_req = req_r;

    // helper logic for the checks below; nothing in the datapath reads it
    logic        bus_new;      // request seen for the first time
    logic [11:0] gap_r;        // cycles since the last tick
    logic        clean_r;      // a whole tap period has run undisturbed

    // a request is fresh while ack has not yet been given
    assign bus_new = wb_cyc_i && wb_stb_i && !ack_r;

    // tick spacing counter; a clear or control write restarts it,
    // since either one may shift the tap phase and cut the first period
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            gap_r   <= 12'h000;
            clean_r <= 1'b0;
        end
        else if (div_clr || wr_ctrl)
        begin
            gap_r   <= 12'h000;
            clean_r <= 1'b0;
        end
        else if (tick)
        begin
            gap_r   <= 12'h000;
            clean_r <= 1'b1;
        end
        else
            gap_r <= gap_r + 12'h001;
    end

    // command bits never stick in the register
    a_clear_reads_zero: assert property (@(posedge ref_clk) disable iff (reset) // R04
        ctrl_r[1:0] == 2'b00) else $error("clear bits not zero");

    // a counter clear lands on the next edge, even against a tick
    a_cnt_clear: assert property (@(posedge ref_clk) disable iff (reset) // R03
        cnt_clr |=> cnt_r == 8'h00) else $error("counter not cleared");

    // overflow while armed raises the request one cycle later
    a_overflow_req: assert property (@(posedge ref_clk) disable iff (reset) // R05
        wdt_en && tick && !cnt_clr && cnt_r == 8'hFF |=> req_r)
        else $error("overflow missed");

    // a disarmed dog never raises a new request
    a_no_req_off: assert property (@(posedge ref_clk) disable iff (reset) // R01
        !wdt_en && !req_r |=> !req_r) else $error("request while disabled");

    // writing the off key disarms the dog from the next cycle
    a_key_decode: assert property (@(posedge ref_clk) disable iff (reset) // R01
        wr_ctrl && wb_dat_i[7:4] == 4'hA |=> !wdt_en)
        else $error("off key did not disarm");

    // any other key arms it; near misses of the key must not disarm
    a_key_armed: assert property (@(posedge ref_clk) disable iff (reset) // R01
        wr_ctrl && wb_dat_i[7:4] != 4'hA |=> wdt_en)
        else $error("other key did not arm");

    // the fastest tap never ticks two cycles running
    a_tick_128: assert property (@(posedge ref_clk) disable iff (reset) // R02
        tick && ctrl_r[3:2] == 2'h2 && !div_clr && !$changed(ctrl_r) |=> !tick)
        else $error("tick too long");

    // the middle tap never ticks two cycles running
    a_tick_1024: assert property (@(posedge ref_clk) disable iff (reset) // R02
        tick && ctrl_r[3:2] == 2'h1 && !div_clr && !$changed(ctrl_r) |=> !tick)
        else $error("tick too long on 1024");

    // the slowest tap never ticks two cycles running
    a_tick_4096: assert property (@(posedge ref_clk) disable iff (reset) // R02
        tick && ctrl_r[3:2] == 2'h0 && !div_clr && !$changed(ctrl_r) |=> !tick)
        else $error("tick too long on 4096");

    // the invalid code gives no ticks at all
    a_sel_invalid: assert property (@(posedge ref_clk) disable iff (reset) // R02
        ctrl_r[3:2] == 2'h3 |-> !tick) else $error("tick on invalid code");

    // each tick moves the count by exactly one, wrapping at the top
    a_cnt_step: assert property (@(posedge ref_clk) disable iff (reset) // R05
        tick && !cnt_clr |=> cnt_r == $past(cnt_r) + 8'h01)
        else $error("counter did not step");

    // ack is a single-cycle pulse
    a_ack_pulse: assert property (@(posedge ref_clk) disable iff (reset)
        ack_r |=> !ack_r) else $error("ack held");

    // every fresh request is answered on the very next edge
    a_ack_latency: assert property (@(posedge ref_clk) disable iff (reset)
        bus_new |=> ack_r) else $error("ack late");

    // ack only follows a request that was present the cycle before
    a_ack_cause: assert property (@(posedge ref_clk) disable iff (reset)
        ack_r |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");

    // no request, no ack on the next edge
    a_ack_idle: assert property (@(posedge ref_clk) disable iff (reset)
        !(wb_cyc_i && wb_stb_i) |=> !ack_r)
        else $error("ack while idle");

    // registers are one byte wide, the upper lanes always read zero
    a_dat_upper: assert property (@(posedge ref_clk) disable iff (reset)
        wb_dat_o[31:8] == 24'h000000) else $error("upper read lanes not zero");

    // read data stand until the next access is taken
    a_dat_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !bus_new |=> $stable(wb_dat_o))
        else $error("read data moved between accesses");

    // a control write stores key and tap select as written
    a_ctrl_store: assert property (@(posedge ref_clk) disable iff (reset) // R02
        wr_ctrl |=> ctrl_r[7:2] == $past(wb_dat_i[7:2]))
        else $error("control write lost");

    // without a write the control register holds
    a_ctrl_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !wr_ctrl |=> $stable(ctrl_r)) else $error("control changed unasked");

    // a write with byte lane 0 off is acked but leaves the register alone
    a_lane_off: assert property (@(posedge ref_clk) disable iff (reset)
        bus_new && wb_we_i && !wb_sel_i[0] |=> $stable(ctrl_r))
        else $error("write without lane 0 taken");

    // a divider clear restarts the chain, so no tick follows at once
    a_div_clear: assert property (@(posedge ref_clk) disable iff (reset) // R03
        div_clr |=> !tick) else $error("tick right after divider clear");

    // a zero in the clear bits leaves the count to the ticks
    a_cnt_hold: assert property (@(posedge ref_clk) disable iff (reset) // R03
        !tick && !cnt_clr |=> $stable(cnt_r))
        else $error("count moved without tick");

    // code 11 freezes the count unless software clears it
    a_cnt_frozen: assert property (@(posedge ref_clk) disable iff (reset) // R02
        ctrl_r[3:2] == 2'h3 && !cnt_clr |=> $stable(cnt_r))
        else $error("count moved on invalid code");

    // whole tap periods, measured by the helper; the gap count at
    // each tick reads one less than the divide ratio
    a_period_4096: assert property (@(posedge ref_clk) disable iff (reset) // R02
        tick && clean_r && ctrl_r[3:2] == btw_pkg::SEL_4096 |-> gap_r == btw_pkg::DIV_4096_MAX)
        else $error("tick period not 4096");

    a_period_1024: assert property (@(posedge ref_clk) disable iff (reset) // R02
        tick && clean_r && ctrl_r[3:2] == btw_pkg::SEL_1024 |-> gap_r == btw_pkg::DIV_1024_MAX)
        else $error("tick period not 1024");

    a_period_128: assert property (@(posedge ref_clk) disable iff (reset) // R02
        tick && clean_r && ctrl_r[3:2] == btw_pkg::SEL_128 |-> gap_r == btw_pkg::DIV_128_MAX)
        else $error("tick period not 128");

    // the top of the count wraps back to zero
    a_cnt_wrap: assert property (@(posedge ref_clk) disable iff (reset) // R05
        tick && !cnt_clr && cnt_r == btw_pkg::CNT_MAX |=> cnt_r == btw_pkg::CNT_RESET)
        else $error("count did not wrap");

    // once raised the request stays until a system reset; disarming
    // afterwards must not hide an overflow that already happened
    a_req_sticky: assert property (@(posedge ref_clk) disable iff (reset) // R05
        req_r |=> req_r) else $error("request dropped");

    // the request rises only from an overflow while armed
    a_req_cause: assert property (@(posedge ref_clk) disable iff (reset) // R05
        $rose(req_r) |-> $past(wdt_en && tick && cnt_r == btw_pkg::CNT_MAX))
        else $error("request without overflow");

    // reads return the addressed register as it stood when taken
    a_read_ctrl: assert property (@(posedge ref_clk) disable iff (reset) // R04
        bus_new && wb_adr_i == btw_pkg::CTRL_OFS |=> wb_dat_o[7:0] == $past(ctrl_r))
        else $error("control read wrong");

    a_read_count: assert property (@(posedge ref_clk) disable iff (reset) // R05
        bus_new && wb_adr_i == btw_pkg::COUNT_OFS |=> wb_dat_o[7:0] == $past(cnt_r))
        else $error("count read wrong");

    // unmapped places read zero
    a_read_unmapped: assert property (@(posedge ref_clk) disable iff (reset)
        bus_new && wb_adr_i != btw_pkg::CTRL_OFS && wb_adr_i != btw_pkg::COUNT_OFS
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    // the command bits act only through a taken write to the control place;
    // a stray pulse here would silently reset the dog's count
    a_clr_source: assert property (@(posedge ref_clk) disable iff (reset) // R03
        !wr_ctrl |-> !div_clr && !cnt_clr)
        else $error("clear pulse without write");

    // a clear bit written as one is seen as one pulse, not held
    a_clr_pulse: assert property (@(posedge ref_clk) disable iff (reset) // R04
        cnt_clr |=> !cnt_clr) else $error("counter clear held");

    // the armed state follows the stored key and nothing else
    a_arm_hold: assert property (@(posedge ref_clk) disable iff (reset) // R01
        !wr_ctrl |=> $stable(wdt_en)) else $error("arming changed unasked");

    // the control register leaves reset with the dog armed on the slow tap;
    // checked on the first edge after reset falls, when no write can have landed
    a_reset_armed: assert property (@(posedge ref_clk) disable iff (reset) // R01
        $fell(reset) |-> wdt_en) else $error("dog not armed after reset");
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        ref_clk = 1'b0; // 50 MHz clock
    logic        reset   = 1'b1; // async, active high
    logic        cyc     = 1'b0; // bus master side
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] wdat    = 32'h0;
    logic [3:0]  sel     = 4'h0;
    logic [31:0] rdat;           // slave answers
    logic        ack;
    logic        req;            // watchdog reset request
    logic [7:0]  q;              // last read byte
    logic [3:0]  lane    = 4'hF; // byte enables for the next call
    int          err_count = 0;
    int          checked   = 0;
    int          div[3] = '{4096, 1024, 128}; // tap per select code
    int          nper[3] = '{2, 3, 5};        // ticks to wait per code
    btw_ctrl dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wdt_reset_req(req));
    // free-running clock
    always #10 ref_clk = ~ref_clk;
    task automatic end_of_test();
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one classic cycle; held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d}; sel <= lane;
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = rdat[7:0];
        if (!w) chk("rd upper", 8'h00, {7'h0, |rdat[31:8]});
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // hang guard, a little beyond the expected run length
    initial
    begin
        #(20 * 100000);
        err_count++;
        end_of_test();
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        bus(1'b0, btw_pkg::CTRL_OFS, 8'h00); chk("ctrl reset", 8'h00, q);
        // clear bits written as one must read back zero
        bus(1'b1, btw_pkg::CTRL_OFS, 8'hAB);
        bus(1'b0, btw_pkg::CTRL_OFS, 8'h00); chk("ctrl rd", 8'hA8, q);
        // unmapped place: write ignored, reads zero
        bus(1'b1, 8'h10, 8'h5A);
        bus(1'b0, 8'h10, 8'h00); chk("unmapped", 8'h00, q);
        // each tap: clear both, count ticks with half a tick of margin
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, btw_pkg::CTRL_OFS, {4'hA, i[1:0], 2'b11});
            repeat (div[i] * nper[i] + div[i] / 2) @(posedge ref_clk);
            bus(1'b0, btw_pkg::COUNT_OFS, 8'h00); chk("count", nper[i][7:0], q);
        end
        // zero in the clear bits leaves the count alone
        bus(1'b1, btw_pkg::CTRL_OFS, 8'hA8);
        bus(1'b0, btw_pkg::COUNT_OFS, 8'h00); chk("no clear", 8'h05, q);
        // invalid tap code: no ticks, the count stays frozen
        bus(1'b1, btw_pkg::CTRL_OFS, 8'hAC);
        repeat (300) @(posedge ref_clk);
        bus(1'b0, btw_pkg::COUNT_OFS, 8'h00); chk("frozen", 8'h05, q);
        // write with lane 0 off is acked and ignored
        lane = 4'hE;
        bus(1'b1, btw_pkg::CTRL_OFS, 8'h03);
        lane = 4'hF;
        bus(1'b0, btw_pkg::CTRL_OFS, 8'h00); chk("lane off", 8'hAC, q);
        // dog off: a full wrap raises no request
        bus(1'b1, btw_pkg::CTRL_OFS, 8'hAB);
        repeat (128 * 256 + 64) @(posedge ref_clk);
        chk("req off", 8'h00, {7'h0, req});
        bus(1'b0, btw_pkg::COUNT_OFS, 8'h00); chk("wrap", 8'h00, q);
        // dog on with a near key: quiet just before overflow, set after
        bus(1'b1, btw_pkg::CTRL_OFS, 8'hBB);
        repeat (128 * 255 + 64) @(posedge ref_clk);
        chk("req early", 8'h00, {7'h0, req});
        repeat (128) @(posedge ref_clk);
        chk("req set", 8'h01, {7'h0, req});
        end_of_test();
    end
endmodule
